// [test/csfr_asserts.sv]
// Port checker for the processor status flag register
`timescale 1ns/1ps
`default_nettype none
module csfr_asserts
   import csfr_pkg::*;
#(
   parameter int W = DATA_W // Byte width
) (
   input wire logic CLK_I, // Clock
   input wire logic RSTN_I, // Reset
   input wire logic PSEL_I, // Select
   input wire logic PENABLE_I, // Enable
   input wire logic PWRITE_I, // Direction
   input wire logic [APB_AW-1:0] PADDR_I, // Address
   input wire logic [APB_DW-1:0] PWDATA_I, // Write data
   input wire logic [APB_DW-1:0] PRDATA_O, // Read data
   input wire logic PREADY_O, // Ready
   input wire logic PSLVERR_O, // Error
   input wire logic ALU_VALID_I, // Op valid
   input wire csfr_op_t ALU_OP_I, // Op code
   input wire logic [W-1:0] ALU_A_I, // Operand a
   input wire logic [W-1:0] ALU_B_I, // Operand b
   input wire logic [W-1:0] ALU_RESULT_O, // Result
   input wire logic WDT_TIMEOUT_I, // Expiry
   input wire logic KICK_I, // Kick
   input wire logic HALT_I, // Halt
   input wire logic [W-1:0] FLAGS_O, // Flags
   input wire logic IRQ_O // Interrupt
);
   logic [W-1:0] a_q;
   logic [W-1:0] b_q;
   logic [W:0] sum_w;
   logic [4:0] nib_w;
   logic quiet;
   ////////////////////////////////////////////////////////////////////////////
   // Operands of the previous cycle, so sums need no expression in past
   always_ff @(posedge CLK_I) begin
      a_q <= ALU_A_I;
      b_q <= ALU_B_I;
   end
   assign sum_w = {1'b0, a_q} + {1'b0, b_q};
   assign nib_w = {1'b0, a_q[3:0]} + {1'b0, b_q[3:0]};
   assign quiet = !WDT_TIMEOUT_I && !KICK_I && !HALT_I;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   ////////////////////////////////////////////////////////////////////////////
   a_expiry_set: assert property (WDT_TIMEOUT_I |=> FLAGS_O[BIT_WDT])
      else $error("expiry flag not set");
   a_kick_clear: assert property (KICK_I && !HALT_I |=> !FLAGS_O[BIT_HALT])
      else $error("halt flag not cleared by kick");
   a_halt_set: assert property (HALT_I |=> FLAGS_O[BIT_HALT])
      else $error("halt flag not set");
   a_expiry_clear: assert property ((KICK_I || HALT_I) && !WDT_TIMEOUT_I |=> !FLAGS_O[BIT_WDT])
      else $error("expiry flag not cleared");
   a_sys_hold: assert property (quiet |=> $stable(FLAGS_O[5:4]))
      else $error("system flag changed without event");
   a_upper_zero: assert property (FLAGS_O[7:6] == 2'h0)
      else $error("upper flag bits not zero");
   a_null_logic: assert property (ALU_VALID_I && ALU_OP_I inside {OP_AND, OP_OR, OP_XOR}
      |=> FLAGS_O[BIT_Z] == (ALU_RESULT_O == '0))
      else $error("null flag wrong");
   a_add_carry: assert property (ALU_VALID_I && ALU_OP_I == OP_ADD
      |=> FLAGS_O[BIT_C] == sum_w[W] && FLAGS_O[BIT_NIB] == nib_w[4])
      else $error("add carry flags wrong");
   a_add_wrap: assert property (ALU_VALID_I && ALU_OP_I == OP_ADD
      |=> FLAGS_O[BIT_WRAP] == (a_q[W-1] == b_q[W-1] && sum_w[W-1] != a_q[W-1]))
      else $error("sign wrap flag wrong");
   a_rot_carry: assert property (ALU_VALID_I && ALU_OP_I == OP_RLC
      |=> FLAGS_O[BIT_C] == a_q[W-1] && ALU_RESULT_O[0] == $past(FLAGS_O[BIT_C]))
      else $error("rotate carry wrong");
endmodule : csfr_asserts

bind csfr_top csfr_asserts #(.W(W)) csfr_asserts_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .ALU_VALID_I(ALU_VALID_I), .ALU_OP_I(ALU_OP_I), .ALU_A_I(ALU_A_I), .ALU_B_I(ALU_B_I),
   .ALU_RESULT_O(ALU_RESULT_O), .WDT_TIMEOUT_I(WDT_TIMEOUT_I), .KICK_I(KICK_I),
   .HALT_I(HALT_I), .FLAGS_O(FLAGS_O), .IRQ_O(IRQ_O));
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench of the processor status flag register
`timescale 1ns/1ps
`default_nettype none
module testbench
   import csfr_pkg::*;
;
   logic CLK_I, RSTN_I, PSEL_I, PENABLE_I, PWRITE_I, ALU_VALID_I, WDT_TIMEOUT_I, KICK_I, HALT_I;
   logic [APB_AW-1:0] PADDR_I;
   logic [APB_DW-1:0] PWDATA_I, PRDATA_O, rd;
   logic PREADY_O, PSLVERR_O, IRQ_O, er;
   csfr_op_t ALU_OP_I;
   logic [7:0] ALU_A_I, ALU_B_I, ALU_RESULT_O, FLAGS_O;
   int error_cnt = 0;
   int checks_done = 0;
   // Op table; the rotate, ADC and SBC rows lean on the carry left by the row before
   localparam csfr_op_t OPS [10] = '{OP_ADD, OP_SUB, OP_RLC, OP_RRC, OP_OR, OP_AND,
      OP_ADC, OP_ADC, OP_SBC, OP_XOR};
   localparam logic [7:0] AS [10] = '{8'h7f, 8'h10, 8'h80, 8'h00, 8'h01, 8'h0f, 8'hff,
      8'hff, 8'h80, 8'haa};
   localparam logic [7:0] BS [10] = '{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'hf0, 8'h00,
      8'h01, 8'h01, 8'haa};
   localparam logic [7:0] RS [10] = '{8'h80, 8'h00, 8'h01, 8'h80, 8'h01, 8'h00, 8'hff,
      8'h00, 8'h7f, 8'h00};
   localparam logic [3:0] FS [10] = '{4'ha, 4'h7, 4'h7, 4'h6, 4'h2, 4'h6, 4'h0, 4'h7,
      4'h9, 4'hd};

   csfr_top #(.W(8)) csfr_top_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
      .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
      .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
      .ALU_VALID_I(ALU_VALID_I), .ALU_OP_I(ALU_OP_I), .ALU_A_I(ALU_A_I), .ALU_B_I(ALU_B_I),
      .ALU_RESULT_O(ALU_RESULT_O), .WDT_TIMEOUT_I(WDT_TIMEOUT_I), .KICK_I(KICK_I),
      .HALT_I(HALT_I), .FLAGS_O(FLAGS_O), .IRQ_O(IRQ_O));

   ////////////////////////////////////////////////////////////////////////////
   // Clock at 25 MHz
   initial begin
      CLK_I = 1'b0;
      forever #20 CLK_I = ~CLK_I;
   end

   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task end_sim;
      $display("errors=%0d checks=%0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim

   // One bus transfer; read data and error taken at the ready edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK_I);
      PSEL_I <= 1'b1;
      PENABLE_I <= 1'b0;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      @(posedge CLK_I);
      while (PREADY_O !== 1'b1) @(posedge CLK_I);
      rd = PRDATA_O;
      er = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
      #1;
   endtask : apb

   // Event pulse, then system flags after the sampling edge
   task ev(input logic w, input logic k, input logic h, input logic [1:0] e);
      @(posedge CLK_I);
      WDT_TIMEOUT_I <= w;
      KICK_I <= k;
      HALT_I <= h;
      @(posedge CLK_I);
      WDT_TIMEOUT_I <= 1'b0;
      KICK_I <= 1'b0;
      HALT_I <= 1'b0;
      #1;
      chk(FLAGS_O[5:4], e);
   endtask : ev

   task t_alu;
      for (int i = 0; i < 10; i++) begin
         @(posedge CLK_I);
         ALU_VALID_I <= 1'b1;
         ALU_OP_I <= OPS[i];
         ALU_A_I <= AS[i];
         ALU_B_I <= BS[i];
         @(posedge CLK_I);
         ALU_VALID_I <= 1'b0;
         #1;
         chk(ALU_RESULT_O, RS[i]);
         chk(FLAGS_O, {4'h0, FS[i]});
      end
   endtask : t_alu

   task t_sys;
      ev(1'b1, 1'b0, 1'b0, 2'b10);
      ev(1'b0, 1'b0, 1'b1, 2'b01);
      ev(1'b1, 1'b0, 1'b0, 2'b11);
      ev(1'b0, 1'b1, 1'b0, 2'b00);
      ev(1'b0, 1'b0, 1'b1, 2'b01);
   endtask : t_sys

   // Writes reach only the four arithmetic flags
   task t_bus;
      apb(1'b1, OFS_FLAGS, 32'hffff_ffff);
      chk(FLAGS_O, 8'h1f);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd, 32'h1f);
      apb(1'b1, OFS_FLAGS, 32'h0);
      chk(FLAGS_O, 8'h10);
      apb(1'b0, 12'h00c, 32'h0);
      chk({er, rd}, 33'h1_0000_0000);
      apb(1'b1, 12'h00c, 32'hff);
      chk({er, FLAGS_O}, 9'h110);
   endtask : t_bus

   // Sticky events, mask and write-one-to-clear
   task t_irq;
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk({IRQ_O, rd}, 33'h7);
      apb(1'b1, OFS_IRQ_MASK, 32'h4);
      chk(IRQ_O, 1'b1);
      apb(1'b1, OFS_IRQ_STAT, 32'h4);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk({IRQ_O, rd}, 33'h3);
      apb(1'b1, OFS_IRQ_MASK, 32'h3);
      chk(IRQ_O, 1'b1);
      apb(1'b1, OFS_IRQ_STAT, 32'h3);
      apb(1'b0, OFS_IRQ_MASK, 32'h0);
      chk({IRQ_O, rd}, 33'h3);
   endtask : t_irq

   // A second reset clears the system flags again
   task t_reset;
      @(posedge CLK_I);
      RSTN_I <= 1'b0;
      @(posedge CLK_I);
      #1;
      chk({IRQ_O, FLAGS_O}, 9'h000);
      @(posedge CLK_I);
      RSTN_I <= 1'b1;
   endtask : t_reset

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {RSTN_I, PSEL_I, PENABLE_I, PWRITE_I, ALU_VALID_I, WDT_TIMEOUT_I, KICK_I, HALT_I} = '0;
      PADDR_I = '0;
      PWDATA_I = '0;
      ALU_OP_I = OP_NONE;
      ALU_A_I = '0;
      ALU_B_I = '0;
      repeat (5) @(posedge CLK_I);
      chk({IRQ_O, PREADY_O, FLAGS_O}, 10'h100);
      RSTN_I <= 1'b1;
      t_alu();
      t_sys();
      t_bus();
      t_irq();
      t_reset();
      end_sim();
   end

   // Watchdog, far beyond the roughly 75 cycles the run needs
   initial begin
      #100us;
      error_cnt++;
      end_sim();
   end
endmodule : testbench
`default_nettype wire

// [verilog/csfr_alu_flags.sv]
// Result and flag computation for one operation of the execution unit
`timescale 1ns/1ps
`default_nettype none
module csfr_alu_flags
   import csfr_pkg::*;
#(
   parameter int W = DATA_W // Operand width
) (
   input wire csfr_op_t op_i, // Operation code
   input wire logic [W-1:0] a_i, // First operand
   input wire logic [W-1:0] b_i, // Second operand
   input wire logic cin_i, // Current carry flag
   output logic [W-1:0] res_o, // Result byte
   output logic c_o, // New carry
   output logic nib_o, // New nibble carry
   output logic z_o, // New null result
   output logic wrap_o, // New sign wrap
   output logic upd_c_o, // Carry affected
   output logic upd_nib_o, // Nibble carry affected
   output logic upd_z_o, // Null result affected
   output logic upd_wrap_o // Sign wrap affected
);

   logic [W-1:0] opb;
   logic cin_add;
   logic [W:0] sum;
   logic [NIB_W:0] lo_sum;
   logic [W-1:0] msb_in;

   // Subtraction adds the inverted operand, so carry out means no borrow
   always_comb begin
      opb = b_i;
      cin_add = 1'b0;
      case (op_i)
         OP_ADC: cin_add = cin_i;
         OP_SUB: begin
            opb = ~b_i;
            cin_add = 1'b1;
         end
         OP_SBC: begin
            opb = ~b_i;
            cin_add = cin_i;
         end
         default: cin_add = 1'b0;
      endcase
   end

   // Full sum, low nibble sum, and sum below the top bit
   assign sum = {1'b0, a_i} + {1'b0, opb} + {{W{1'b0}}, cin_add};
   assign lo_sum = {1'b0, a_i[NIB_W-1:0]} + {1'b0, opb[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin_add};
   assign msb_in = {1'b0, a_i[W-2:0]} + {1'b0, opb[W-2:0]} + {{(W-1){1'b0}}, cin_add};

   // Result, flag values and which flags the operation touches
   always_comb begin
      res_o = sum[W-1:0];
      c_o = sum[W];
      nib_o = lo_sum[NIB_W];
      wrap_o = msb_in[W-1] ^ sum[W];
      upd_c_o = 1'b0;
      upd_nib_o = 1'b0;
      upd_z_o = 1'b0;
      upd_wrap_o = 1'b0;
      case (op_i)
         OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
            upd_c_o = 1'b1;
            upd_nib_o = 1'b1;
            upd_z_o = 1'b1;
            upd_wrap_o = 1'b1;
         end
         OP_AND: begin
            res_o = a_i & b_i;
            upd_z_o = 1'b1;
         end
         OP_OR: begin
            res_o = a_i | b_i;
            upd_z_o = 1'b1;
         end
         OP_XOR: begin
            res_o = a_i ^ b_i;
            upd_z_o = 1'b1;
         end
         OP_RLC: begin
            res_o = {a_i[W-2:0], cin_i};
            c_o = a_i[W-1];
            upd_c_o = 1'b1;
         end
         OP_RRC: begin
            res_o = {cin_i, a_i[W-1:1]};
            c_o = a_i[0];
            upd_c_o = 1'b1;
         end
         default: res_o = a_i;
      endcase
      z_o = (res_o == '0);
   end

endmodule : csfr_alu_flags
`default_nettype wire

// [verilog/csfr_irq.sv]
// Sticky event status with mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module csfr_irq
   import csfr_pkg::*;
#(
   parameter int W = IRQ_W // Number of events
) (
   input wire logic clk_i, // Core clock
   input wire logic rstn_i, // Async reset, active low
   input wire logic [W-1:0] evt_i, // Event pulses
   input wire logic clr_we_i, // Status write strobe
   input wire logic [W-1:0] clr_i, // Ones clear status bits
   input wire logic mask_we_i, // Mask write strobe
   input wire logic [W-1:0] mask_i, // New mask value
   output logic [W-1:0] stat_o, // Sticky status
   output logic [W-1:0] mask_o, // Enable mask
   output logic irq_o // Interrupt level
);

   logic [W-1:0] stat_q;
   logic [W-1:0] mask_q;
   logic [W-1:0] clr_d;

   // Write one to clear; a new event in the same cycle survives
   assign clr_d = clr_we_i ? clr_i : '0;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stat_q <= IRQ_RST;
      end else begin
         stat_q <= (stat_q & ~clr_d) | evt_i;
      end
   end

   // Mask register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_q <= IRQ_RST;
      end else if (mask_we_i) begin
         mask_q <= mask_i;
      end
   end

   assign stat_o = stat_q;
   assign mask_o = mask_q;
   assign irq_o = |(stat_q & mask_q);

endmodule : csfr_irq
`default_nettype wire

// [verilog/csfr_pkg.sv]
// Package: constants and types of the cpu status flag register block
`default_nettype none
package csfr_pkg;

   // Data widths
   localparam int DATA_W = 8;
   localparam int NIB_W = 4;
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;

   // Flag bit positions inside the processor flags byte
   localparam int BIT_C = 0;
   localparam int BIT_NIB = 1;
   localparam int BIT_Z = 2;
   localparam int BIT_WRAP = 3;
   localparam int BIT_HALT = 4;
   localparam int BIT_WDT = 5;
   localparam int ARITH_W = 4;

   // Reset values
   localparam logic [ARITH_W-1:0] ARITH_RST = 4'h0;
   localparam logic SYS_FLAG_RST = 1'b0;

   // Register byte offsets on the bus
   localparam logic [APB_AW-1:0] OFS_FLAGS = 12'h000;
   localparam logic [APB_AW-1:0] OFS_IRQ_STAT = 12'h004;
   localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 12'h008;

   // Interrupt status layout
   localparam int IRQ_W = 3;
   localparam int IRQ_WDT = 0;
   localparam int IRQ_HALT = 1;
   localparam int IRQ_WRAP = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // Operation codes presented by the execution unit
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ADD = 4'h1,
      OP_ADC = 4'h2,
      OP_SUB = 4'h3,
      OP_SBC = 4'h4,
      OP_AND = 4'h5,
      OP_OR = 4'h6,
      OP_XOR = 4'h7,
      OP_RLC = 4'h8,
      OP_RRC = 4'h9
   } csfr_op_t;

   // Word-aligned address match
   function automatic logic csfr_hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] ofs);
      return a[APB_AW-1:2] == ofs[APB_AW-1:2];
   endfunction : csfr_hit

endpackage : csfr_pkg
`default_nettype wire

// [verilog/csfr_top.sv]
// Processor status flag register with bus access and event interrupt
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// - Watchdog time-out sets the watchdog expiry flag, bit 5.
// - Power-up and watchdog kick clear the halt entered flag, bit 4.
// - Halt instruction sets the halt entered flag.
// - Sign wrap flag, bit 3: carry into top bit differs from carry out.
// - Null result flag, bit 2: set on zero result, else cleared.
// - Nibble flag, bit 1: low nibble carry, or no nibble borrow.
// - Carry, bit 0: addition carry out, or subtraction without borrow.
// - Rotate through carry shifts carry in and captures bit shifted out.
// - Software writes never change the watchdog expiry or halt flags.
// - Power-up, watchdog kick and halt clear the watchdog expiry flag.
module csfr_top
   import csfr_pkg::*;
#(
   parameter int W = DATA_W // Data byte width
) (
   input wire logic CLK_I, // Core clock, 25 MHz
   input wire logic RSTN_I, // Async reset, active low
   input wire logic PSEL_I, // APB select
   input wire logic PENABLE_I, // APB enable
   input wire logic PWRITE_I, // APB direction
   input wire logic [APB_AW-1:0] PADDR_I, // APB byte address
   input wire logic [APB_DW-1:0] PWDATA_I, // APB write data
   output logic [APB_DW-1:0] PRDATA_O, // APB read data
   output logic PREADY_O, // APB ready
   output logic PSLVERR_O, // APB error, unmapped
   input wire logic ALU_VALID_I, // Operation executes
   input wire csfr_op_t ALU_OP_I, // Operation code
   input wire logic [W-1:0] ALU_A_I, // First operand
   input wire logic [W-1:0] ALU_B_I, // Second operand
   output logic [W-1:0] ALU_RESULT_O, // Last result
   input wire logic WDT_TIMEOUT_I, // Watchdog expiry pulse
   input wire logic KICK_I, // Watchdog kick pulse
   input wire logic HALT_I, // Halt pulse
   output logic [W-1:0] FLAGS_O, // Flags byte
   output logic IRQ_O // Interrupt level
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [ARITH_W-1:0] arith_q;
   logic [ARITH_W-1:0] arith_d;
   logic wdt_q;
   logic wdt_d;
   logic halt_q;
   logic halt_d;
   logic [W-1:0] result_q;
   logic [APB_DW-1:0] rdata_q;
   logic [APB_DW-1:0] rdata_d;
   logic err_q;

   logic setup;
   logic access;
   logic wr_en;
   logic hit_flags;
   logic hit_stat;
   logic hit_mask;
   logic hit_any;
   logic wr_flags;
   logic wr_stat;
   logic wr_mask;

   logic [W-1:0] alu_res;
   logic alu_c;
   logic alu_nib;
   logic alu_z;
   logic alu_wrap;
   logic upd_c;
   logic upd_nib;
   logic upd_z;
   logic upd_wrap;

   logic [W-1:0] flags;
   logic [IRQ_W-1:0] evt;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Register map and behaviour summary
   //
   // Word 0: flags byte; bits 3:0 writable, bits 5:4 read only
   // Word 1: event status, write one to clear
   // Word 2: event enable mask, plain read and write
   // Other words: error response, write dropped, read zero
   //
   // Flags byte layout, low bit first:
   //    carry, nibble carry, null result, sign wrap,
   //    halt entered, watchdog expiry, two zero bits
   //
   // Event vector bits, low bit first:
   //    watchdog expiry, halt entered, operation set sign wrap
   //
   // Same-cycle priorities:
   //    operation over bus write, for the flags it touches
   //    time-out over kick or halt, for the expiry flag
   //    halt over kick, for the halt entered flag
   //    new event over write-one-to-clear, for status bits
   //
   // Timing seen by the core:
   //    flags change on the edge that samples the operation
   //    carry in of ADC, SBC and rotates comes from the stored carry flag,
   //    so back-to-back operations chain their carries
   //
   // Reset: system flags, result, status, mask and read data clear;
   // arithmetic flags also clear, where a real part leaves them open
   //
   // Limitation: read data is taken in the setup cycle, so an
   // operation in the setup cycle is not yet in the returned byte

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   // Setup and access phases of a transfer
   assign setup = PSEL_I & ~PENABLE_I;
   assign access = PSEL_I & PENABLE_I;

   // Address decode, shared by read mux and write strobes
   assign hit_flags = csfr_hit(PADDR_I, OFS_FLAGS);
   assign hit_stat = csfr_hit(PADDR_I, OFS_IRQ_STAT);
   assign hit_mask = csfr_hit(PADDR_I, OFS_IRQ_MASK);
   assign hit_any = hit_flags | hit_stat | hit_mask;

   // No register here needs extra time, so ready is tied high; the
   // error flag is the only response that varies by address
   //
   // Zero wait states: every access completes in its first access cycle
   assign PREADY_O = 1'b1;
   assign wr_en = access & PWRITE_I & PREADY_O;

   // Per-register write strobes; an unmapped write raises none of them
   assign wr_flags = wr_en & hit_flags;
   assign wr_stat = wr_en & hit_stat;
   assign wr_mask = wr_en & hit_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Flag computation

   // Carry in for ADC, SBC and rotate is the live carry flag
   // Logic ops and rotates leave the untouched flags as they were
   csfr_alu_flags #(
      .W(W)
   ) u_alu_flags (
      .op_i(ALU_OP_I),
      .a_i(ALU_A_I),
      .b_i(ALU_B_I),
      .cin_i(arith_q[BIT_C]),
      .res_o(alu_res),
      .c_o(alu_c),
      .nib_o(alu_nib),
      .z_o(alu_z),
      .wrap_o(alu_wrap),
      .upd_c_o(upd_c),
      .upd_nib_o(upd_nib),
      .upd_z_o(upd_z),
      .upd_wrap_o(upd_wrap)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic flags

   // A bus write loads all four flags at once; software cannot
   // touch the two system flags through this path
   // Next arithmetic flags; an executing operation beats a bus write
   // for the flags it touches, since it is the later instruction effect
   always_comb begin
      arith_d = arith_q;
      if (wr_flags) begin
         arith_d = PWDATA_I[ARITH_W-1:0];
      end
      if (ALU_VALID_I) begin
         if (upd_c) begin
            arith_d[BIT_C] = alu_c;
         end
         if (upd_nib) begin
            arith_d[BIT_NIB] = alu_nib;
         end
         if (upd_z) begin
            arith_d[BIT_Z] = alu_z;
         end
         if (upd_wrap) begin
            arith_d[BIT_WRAP] = alu_wrap;
         end
      end
   end

   // Arithmetic flags have no defined power-up value; zero is used here
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         arith_q <= ARITH_RST;
      end else begin
         arith_q <= arith_d;
      end
   end

   // Result byte of the last operation
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         result_q <= '0;
      end else if (ALU_VALID_I) begin
         result_q <= alu_res;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System flags

   // Both system flags are driven only by core pulses; the pulses are
   // single-cycle and already synchronous to the core clock, so no
   // edge detection is needed and a held pulse simply keeps its effect
   //
   // Watchdog expiry: a time-out wins over a same-cycle kick or halt,
   // so the expiry is never lost
   always_comb begin
      wdt_d = wdt_q;
      if (KICK_I || HALT_I) begin
         wdt_d = 1'b0;
      end
      if (WDT_TIMEOUT_I) begin
         wdt_d = 1'b1;
      end
   end

   // Halt entered: halt wins over a same-cycle kick
   always_comb begin
      halt_d = halt_q;
      if (KICK_I) begin
         halt_d = 1'b0;
      end
      if (HALT_I) begin
         halt_d = 1'b1;
      end
   end

   // Bus writes do not reach these flops at all
   // writes ignored
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         wdt_q <= SYS_FLAG_RST;
         halt_q <= SYS_FLAG_RST;
      end else begin
         wdt_q <= wdt_d;
         halt_q <= halt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags byte

   always_comb begin
      flags = '0;
      flags[ARITH_W-1:0] = arith_q;
      flags[BIT_HALT] = halt_q;
      flags[BIT_WDT] = wdt_q;
   end

   // Flags byte and result go straight out from flops
   assign FLAGS_O = flags;
   assign ALU_RESULT_O = result_q;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts

   // Events: expiry, halt entry and an operation that sets sign wrap
   always_comb begin
      evt = '0;
      evt[IRQ_WDT] = WDT_TIMEOUT_I;
      evt[IRQ_HALT] = HALT_I;
      evt[IRQ_WRAP] = ALU_VALID_I & upd_wrap & alu_wrap;
   end

   // Status and mask share the event vector layout
   csfr_irq #(
      .W(IRQ_W)
   ) u_irq (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .evt_i(evt),
      .clr_we_i(wr_stat),
      .clr_i(PWDATA_I[IRQ_W-1:0]),
      .mask_we_i(wr_mask),
      .mask_i(PWDATA_I[IRQ_W-1:0]),
      .stat_o(irq_stat),
      .mask_o(irq_mask),
      .irq_o(IRQ_O)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data and error

   // Read mux, unused high bits read zero
   always_comb begin
      rdata_d = '0;
      if (hit_flags) begin
         rdata_d[W-1:0] = flags;
      end else if (hit_stat) begin
         rdata_d[IRQ_W-1:0] = irq_stat;
      end else if (hit_mask) begin
         rdata_d[IRQ_W-1:0] = irq_mask;
      end
   end

   // Sampled in the setup cycle so read data comes from a flop; the
   // value is the state as it stood one cycle before the access edge
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rdata_q <= '0;
      end else if (setup) begin
         rdata_q <= PWRITE_I ? '0 : rdata_d;
      end
   end

   // Unmapped address answered with an error, write dropped
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         err_q <= 1'b0;
      end else if (setup) begin
         err_q <= ~hit_any;
      end
   end

   // Read data from a flop, error qualified by the access phase
   assign PRDATA_O = rdata_q;
   assign PSLVERR_O = access & err_q;

endmodule : csfr_top
`default_nettype wire
